// ### nhmp_pkg.sv
// Contract
// - type/length top bit sent as zero
// - bit six: zero NSAP, one E.164
// - other technologies use format flag zero
// - low six bits length; zero ignores flag
// - no subaddress: type/length zero, no octets
// - ATM with subaddress uses combined family
// - ATM without subaddress: NSAP or E.164 family
// - common header lengths, flags, id, addresses
// - entries follow header with fixed fields
// - reply copies request identifier unchanged
// - reply matched against outstanding requests
// - identifier from 32-bit counter per request
// - retransmission reuses original identifier
// - zero length field occupies no octets
// - code zero ack, nonzero negative ack
// - prefix length N defines equivalence class
// - prefix zero ignored, same as all ones
// - MTU zero selects default or negotiated
// - holding time expiry discards cache
// - mandatory part starts at octet 20
// - unused fields sent zero, ignored on receipt
// - source type/length coded within family
package nhmp_pkg;
    localparam int          FIXED_LEN     = 20;
    localparam int          HDR_LEN       = 8;
    localparam int          CIE_LEN       = 12;
    localparam logic [15:0] AFN_NSAP      = 16'h0003;
    localparam logic [15:0] AFN_E164      = 16'h0008;
    localparam logic [15:0] AFN_COMBINED  = 16'h000F;
    localparam int          TL_RSV_BIT    = 7;
    localparam int          TL_FMT_BIT    = 6;
    localparam logic [7:0]  PREFIX_ONES   = 8'hFF;
    localparam int          NREQ          = 4;
    localparam int          CLK_HZ        = 40000000;
    localparam int          SEC_CYCLES    = CLK_HZ;
    localparam int          FIFO_DEPTH    = 16;
    localparam logic [31:0] ID_RESET      = 32'h00000001;

    // one received octet, framed
    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } nhmp_byte_s;

    // address field being streamed out
    typedef enum logic [2:0] {
        F_SRC_NBMA, F_SRC_SUB, F_SRC_PROTO, F_DST_PROTO,
        F_CLI_NBMA, F_CLI_SUB, F_CLI_PROTO, F_NONE
    } nhmp_field_e;

    typedef struct packed {
        logic [7:0]  data;
        nhmp_field_e field;
        logic        first;
        logic        last;
        logic [7:0]  len;
    } nhmp_out_s;
endpackage : nhmp_pkg

// ### nhmp_fifo.sv
module nhmp_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    // clock
    input  wire logic         clk,
    input  wire logic         rst_n,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0]  wp, rp, next_wp, next_rp;

    assign in_ready  = (wp - rp) != (AW+1)'(D);
    assign out_valid = wp != rp;
    assign out_data  = mem[rp[AW-1:0]];

    // pointer update
    always_comb begin
        next_wp = wp + (AW+1)'(in_valid && in_ready);
        next_rp = rp + (AW+1)'(out_valid && out_ready);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wp <= '0;
            rp <= '0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
        end
        if (in_valid && in_ready) mem[wp[AW-1:0]] <= in_data;
    end
endmodule : nhmp_fifo

// ### nhmp_codec.sv
module nhmp_codec (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // received packet octets, starting at packet octet 0
    input  wire logic                  rx_valid,
    output logic                       rx_ready,
    input  wire nhmp_pkg::nhmp_byte_s  rx_byte,
    input  wire logic [15:0]           rx_pkt_size,
    input  wire logic                  rx_is_reply,
    // decoded address stream
    output logic                       fld_valid,
    input  wire logic                  fld_ready,
    output nhmp_pkg::nhmp_out_s        fld,
    // decoded fixed fields of the last entry
    output logic [31:0]                rx_request_identifier,
    output logic                       rx_nak,
    output logic                       rx_equiv_class,
    output logic [7:0]                 rx_prefix_eff,
    output logic                       rx_mtu_default,
    output logic [15:0]                rx_holding_time,
    output logic                       rx_malformed,
    output logic                       rx_done,
    // reply match against outstanding requests
    input  wire logic [31:0]           rx_src_key,
    output logic                       ack_pulse,
    output logic [1:0]                 ack_slot,
    // request issue
    input  wire logic                  tx_new_req,
    input  wire logic                  tx_retry,
    input  wire logic [1:0]            tx_retry_slot,
    input  wire logic [31:0]           tx_src_key,
    input  wire logic                  tx_reply,
    output logic [31:0]                tx_request_identifier,
    output logic [1:0]                 tx_slot,
    output logic [nhmp_pkg::NREQ-1:0]  pending,
    // type/length and family encoding
    input  wire logic                  enc_e164,
    input  wire logic                  enc_native,
    input  wire logic [5:0]            enc_len,
    input  wire logic                  enc_has_sub,
    input  wire logic                  enc_is_atm,
    output logic [7:0]                 enc_type_len,
    output logic [7:0]                 enc_sub_type_len,
    output logic [15:0]                enc_family,
    // outgoing entry fields
    input  wire logic                  tx_nak,
    input  wire logic [15:0]           tx_hold_in,
    output logic [15:0]                tx_holding_time,
    // cache lifetime
    input  wire logic                  cache_load,
    output logic                       cache_valid,
    // prefix match helper
    input  wire logic [31:0]           cmp_addr_a,
    input  wire logic [31:0]           cmp_addr_b,
    output logic                       cmp_in_class
);
    localparam int NREQ_W = nhmp_pkg::NREQ;
    typedef enum {S_FIXED, S_HDR, S_ADDR, S_CIE, S_DONE} nhmp_state_e;

    nhmp_state_e state, next_state;
    logic [15:0] pos, next_pos;
    logic [7:0]  cnt, next_cnt;
    logic [7:0]  lens [7], next_lens [7];
    nhmp_pkg::nhmp_field_e fidx, next_fidx;
    logic [31:0] rid, next_rid;
    logic [7:0]  code, next_code, pfx, next_pfx;
    logic [15:0] mtu, next_mtu, hold, next_hold;
    logic        bad, next_bad, done, next_done;
    logic        f_in_ready, take;
    int          lo, hi;
    nhmp_pkg::nhmp_out_s f_in;

    // transmit encoding: reserved bit zero, flag, length
    always_comb begin
        enc_type_len = {1'b0, enc_e164 && !enc_native, enc_len};
        enc_sub_type_len = enc_has_sub ? enc_type_len : 8'h00;
        if (enc_is_atm && enc_has_sub) enc_family = nhmp_pkg::AFN_COMBINED;
        else if (enc_is_atm && enc_e164) enc_family = nhmp_pkg::AFN_E164;
        else enc_family = nhmp_pkg::AFN_NSAP;
        tx_holding_time = tx_nak ? 16'h0000 : tx_hold_in;
        cmp_in_class = (rx_prefix_eff == 8'h00) ||
            (((cmp_addr_a ^ cmp_addr_b) >> (6'd32 - (rx_prefix_eff > 8'd32 ?
             6'd32 : 6'(rx_prefix_eff)))) == 32'h0);
    end

    // parser: fixed part skipped except its two type/length octets, header, addresses, entries
    assign take = rx_valid && rx_ready;
    assign rx_ready = (state == S_ADDR) ? f_in_ready : 1'b1; // stall only on stream output
    always_comb begin
        next_state = state; next_pos = pos; next_cnt = cnt; next_lens = lens;
        next_fidx = fidx; next_rid = rid; next_code = code; next_pfx = pfx;
        next_mtu = mtu; next_hold = hold; next_bad = bad; next_done = 1'b0;
        lo = 0; hi = 0;
        f_in = '0;
        if (take) begin
            next_pos = pos + 16'h0001;
            next_cnt = cnt + 8'h01;
            case (state)
                S_FIXED: begin
                    if (pos == 16'(nhmp_pkg::FIXED_LEN - 1)) begin
                        next_state = S_HDR; next_cnt = 8'h00;
                    end
                    // verdict of the last packet stands until the next one begins
                    if (pos == 16'd0) next_bad = 1'b0;
                    if (pos == 16'd18) next_lens[0] = 8'(rx_byte.data[5:0]);
                    if (pos == 16'd19) next_lens[1] = 8'(rx_byte.data[5:0]);
                    if ((pos == 16'd18 || pos == 16'd19) &&
                        rx_byte.data[nhmp_pkg::TL_RSV_BIT]) next_bad = 1'b1;
                end
                S_HDR: begin
                    if (cnt == 8'd0) next_lens[2] = rx_byte.data;
                    if (cnt == 8'd1) next_lens[3] = rx_byte.data;
                    if (cnt >= 8'd4) next_rid = {rid[23:0], rx_byte.data};
                    if (cnt == 8'(nhmp_pkg::HDR_LEN - 1)) begin
                        next_state = S_ADDR; next_fidx = nhmp_pkg::F_SRC_NBMA; next_cnt = 8'h00;
                    end
                end
                S_CIE: begin
                    case (cnt)
                        8'd0: next_code = rx_byte.data;
                        8'd1: next_pfx = rx_byte.data;
                        8'd4: next_mtu[15:8] = rx_byte.data;              // octets 2,3 ignored
                        8'd5: next_mtu[7:0] = rx_byte.data;
                        8'd6: next_hold[15:8] = rx_byte.data;
                        8'd7: next_hold[7:0] = rx_byte.data;
                        8'd8: next_lens[4] = 8'(rx_byte.data[5:0]);
                        8'd9: next_lens[5] = 8'(rx_byte.data[5:0]);
                        8'd10: next_lens[6] = rx_byte.data;
                        default: ;
                    endcase
                    if ((cnt == 8'd8 || cnt == 8'd9) && rx_byte.data[nhmp_pkg::TL_RSV_BIT])
                        next_bad = 1'b1;
                    if (cnt == 8'(nhmp_pkg::CIE_LEN - 1)) begin
                        next_state = S_ADDR; next_fidx = nhmp_pkg::F_CLI_NBMA; next_cnt = 8'h00;
                    end
                end
                S_ADDR: begin
                    f_in.data = rx_byte.data; f_in.field = fidx;
                    f_in.first = (cnt == 8'h00); f_in.last = (next_cnt == lens[fidx]);
                    f_in.len = lens[fidx];
                    if (next_cnt == lens[fidx]) next_cnt = 8'h00;
                end
                default: ;
            endcase
            if (pos >= rx_pkt_size) next_bad = 1'b1;
            if (rx_byte.last) begin
                next_state = S_DONE; next_done = 1'b1;
            end
        end
        // jump over every empty field in one step, so no octet lands in one
        if (next_state == S_ADDR && (state != S_ADDR || (take && next_cnt == 8'h00))) begin
            lo = (state == S_ADDR) ? int'(fidx) + 1 : int'(next_fidx);
            hi = (((state == S_ADDR) ? fidx : next_fidx) <= nhmp_pkg::F_DST_PROTO) ? 3 : 6;
            next_fidx = nhmp_pkg::F_NONE;
            for (int j = 6; j >= 0; j--) begin
                if (j >= lo && j <= hi && lens[j] != 8'h00)
                    next_fidx = nhmp_pkg::nhmp_field_e'(3'(j));
            end
        end
        if (next_state == S_ADDR && next_fidx == nhmp_pkg::F_NONE) begin
            next_state = S_CIE; next_cnt = 8'h00;
        end
        if (state == S_DONE && !rx_valid) begin
            next_state = S_FIXED; next_pos = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= S_FIXED; pos <= '0; cnt <= '0; fidx <= nhmp_pkg::F_NONE; rid <= '0;
            code <= '0; pfx <= '0; mtu <= '0; hold <= '0; bad <= 1'b0; done <= 1'b0;
            for (int i = 0; i < 7; i++) lens[i] <= '0;
        end else begin
            state <= next_state; pos <= next_pos; cnt <= next_cnt; fidx <= next_fidx;
            rid <= next_rid; code <= next_code; pfx <= next_pfx; mtu <= next_mtu;
            hold <= next_hold; bad <= next_bad; done <= next_done; lens <= next_lens;
        end
    end

    // decoded outputs
    assign rx_request_identifier = rid;
    assign rx_nak          = code != 8'h00;
    assign rx_prefix_eff   = (pfx == 8'h00) ? nhmp_pkg::PREFIX_ONES : pfx;
    assign rx_equiv_class  = pfx != 8'h00 && pfx != nhmp_pkg::PREFIX_ONES;
    assign rx_mtu_default  = mtu == 16'h0000;
    assign rx_holding_time = hold;
    assign rx_malformed    = bad;
    assign rx_done         = done;

    // output buffer keeps stream back-pressure on the parser
    nhmp_fifo #(.W($bits(nhmp_pkg::nhmp_out_s)), .D(nhmp_pkg::FIFO_DEPTH)) u_fifo (
        .clk(clk), .rst_n(rst_n),
        .in_valid(take && state == S_ADDR), .in_ready(f_in_ready), .in_data(f_in),
        .out_valid(fld_valid), .out_ready(fld_ready), .out_data(fld));

    // request identifiers and outstanding list
    logic [31:0] ctr, next_ctr, tid, next_tid;
    logic [31:0] ids [NREQ_W], keys [NREQ_W];
    logic [NREQ_W-1:0] pend, next_pend;
    logic [1:0] slot, next_slot, aslot, next_aslot;
    logic ack, next_ack;
    always_comb begin
        next_ctr = ctr; next_tid = tid; next_pend = pend; next_slot = slot;
        next_ack = 1'b0; next_aslot = aslot;
        if (tx_new_req) begin
            next_tid = ctr; next_ctr = ctr + 32'h1;
            next_slot = slot + 2'd1; next_pend[slot] = 1'b1;
        end else if (tx_retry) begin
            next_tid = ids[tx_retry_slot];
        end else if (tx_reply) begin
            next_tid = rid;
        end
        for (int i = 0; i < NREQ_W; i++)
            if (next_done && rx_is_reply && pend[i] && ids[i] == rid &&
                keys[i] == rx_src_key) begin
                next_pend[i] = 1'b0; next_ack = 1'b1; next_aslot = 2'(i);
            end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctr <= nhmp_pkg::ID_RESET; tid <= '0; pend <= '0; slot <= '0;
            ack <= 1'b0; aslot <= '0;
        end else begin
            ctr <= next_ctr; tid <= next_tid; pend <= next_pend; slot <= next_slot;
            ack <= next_ack; aslot <= next_aslot;
        end
        if (tx_new_req) begin
            ids[slot] <= ctr; keys[slot] <= tx_src_key;
        end
    end
    assign tx_request_identifier = tid;
    assign tx_slot = slot;
    assign pending = pend;
    assign ack_pulse = ack;
    assign ack_slot = aslot;

    // holding time countdown for one cached binding
    logic [25:0] sub, next_sub;
    logic [15:0] secs, next_secs;
    always_comb begin
        next_sub = sub; next_secs = secs;
        if (cache_load) begin
            next_secs = hold; next_sub = '0;
        end else if (secs != 16'h0) begin
            next_sub = sub + 26'd1;
            if (sub == 26'(nhmp_pkg::SEC_CYCLES - 1)) begin
                next_sub = '0; next_secs = secs - 16'h1;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sub <= '0; secs <= '0;
        end else begin
            sub <= next_sub; secs <= next_secs;
        end
    end
    assign cache_valid = secs != 16'h0;
endmodule : nhmp_codec

// ### nhmp_codec_checker.sv
module nhmp_codec_checker (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // encoding side
    input wire logic        enc_e164,
    input wire logic        enc_native,
    input wire logic [5:0]  enc_len,
    input wire logic        enc_has_sub,
    input wire logic        enc_is_atm,
    input wire logic [7:0]  enc_type_len,
    input wire logic [7:0]  enc_sub_type_len,
    input wire logic [15:0] enc_family,
    // request and entry side
    input wire logic        tx_nak,
    input wire logic [15:0] tx_holding_time,
    input wire logic        tx_new_req,
    input wire logic [31:0] tx_request_identifier,
    // parse side
    input wire logic        rx_done,
    input wire logic        ack_pulse,
    input wire logic [7:0]  rx_prefix_eff,
    input wire logic [15:0] rx_holding_time,
    input wire logic        rx_malformed,
    input wire logic        cache_load,
    input wire logic        cache_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [31:0] last_id;
    logic        seen;
    // remember the last new identifier; a retry must not move it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            seen    <= 1'b0;
            last_id <= 32'h00000000;
        end else if ($past(tx_new_req)) begin
            seen    <= 1'b1;
            last_id <= tx_request_identifier;
        end
    end
    property p_tl_rsv; enc_type_len[7] == 1'b0; endproperty
    a_tl_rsv: assert property (p_tl_rsv) else $error("reserved bit set");
    property p_fmt; !enc_native && enc_len != 6'h00 |-> enc_type_len[6] == enc_e164; endproperty
    a_fmt: assert property (p_fmt) else $error("format flag wrong");
    property p_native; enc_native |-> !enc_type_len[6]; endproperty
    a_native: assert property (p_native) else $error("native flag wrong");
    property p_len; enc_type_len[5:0] == enc_len; endproperty
    a_len: assert property (p_len) else $error("length field wrong");
    property p_nosub; !enc_has_sub |-> enc_sub_type_len == 8'h00; endproperty
    a_nosub: assert property (p_nosub) else $error("subaddress octet not zero");
    property p_comb; enc_is_atm && enc_has_sub |-> enc_family == 16'h000F; endproperty
    a_comb: assert property (p_comb) else $error("combined family missing");
    property p_atm; enc_is_atm && !enc_has_sub |-> enc_family inside {16'h0003, 16'h0008}; endproperty
    a_atm: assert property (p_atm) else $error("plain family wrong");
    property p_nak_hold; tx_nak |-> tx_holding_time == 16'h0000; endproperty
    a_nak_hold: assert property (p_nak_hold) else $error("nak holding time set");
    property p_incr; tx_new_req && seen && !$past(tx_new_req) |=> tx_request_identifier == last_id + 32'h1; endproperty
    a_incr: assert property (p_incr) else $error("identifier not incremented");
    property p_ack; ack_pulse |-> rx_done; endproperty
    a_ack: assert property (p_ack) else $error("ack not after done");
    property p_prefix; rx_prefix_eff != 8'h00; endproperty
    a_prefix: assert property (p_prefix) else $error("zero prefix not widened");
    property p_cache; cache_load && rx_holding_time != 16'h0000 |-> ##[1:2] cache_valid; endproperty
    a_cache: assert property (p_cache) else $error("cache not valid");
    c_ack: cover property (ack_pulse);
    c_bad: cover property (rx_malformed);
    c_comb: cover property (enc_is_atm && enc_has_sub);
    c_cache: cover property (cache_valid);
endmodule : nhmp_codec_checker

bind nhmp_codec nhmp_codec_checker nhmp_codec_checker_i (.clk, .rst_n, .enc_e164, .enc_native,
    .enc_len, .enc_has_sub, .enc_is_atm, .enc_type_len, .enc_sub_type_len, .enc_family, .tx_nak,
    .tx_holding_time, .tx_new_req, .tx_request_identifier, .rx_done, .ack_pulse, .rx_prefix_eff,
    .rx_holding_time, .rx_malformed, .cache_load, .cache_valid);

// ### nhmp_peer.sv
module nhmp_peer (
    // clock
    input wire logic           clk,
    // octet handshake toward the parser
    input wire logic           rx_ready,
    output logic               rx_valid,
    output nhmp_pkg::nhmp_byte_s rx_byte,
    output logic [15:0]        rx_pkt_size
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rx_valid    = 1'b0;
        rx_byte     = 9'h000;
        rx_pkt_size = 16'h0000;
    end
    // build one packet and hand it over octet by octet
    task automatic send(input logic [7:0] spl, shtl, sstl, code, prefix,
                        input logic [15:0] mtu, hold, input logic [31:0] id);
        logic [7:0] q[$];
        logic [7:0] k;
        int         n;
        k = 8'h00;
        repeat (18) q.push_back(8'h00); // fixed part, unused octets zero
        q.push_back(shtl); // source type/length in family context
        q.push_back(sstl); // zero when no subaddress exists
        q.push_back(spl); // header lengths, flags, identifier
        q.push_back(8'h01);
        q.push_back(8'h00);
        q.push_back(8'h00);
        for (int b = 3; b >= 0; b--) q.push_back(id[8*b+:8]);
        n = int'(shtl[5:0]) + int'(sstl[5:0]) + int'(spl) + 1;
        // zero-length fields take no octets
        repeat (n) begin
            q.push_back(8'hA0 + k);
            k++;
        end
        // one entry, unused octets zero, no client subaddress
        q = {q, code, prefix, 8'h00, 8'h00, mtu[15:8], mtu[7:0], hold[15:8], hold[7:0]};
        q = {q, 8'h00, 8'h00, 8'h01, 8'h00, 8'hA0 + k};
        n = q.size();
        rx_pkt_size <= 16'(n);
        // hold each octet until the parser takes it
        for (int i = 0; i < n; i++) begin
            rx_valid <= 1'b1;
            rx_byte  <= {q[i], i == n - 1};
            do @(posedge clk); while (rx_ready !== 1'b1);
        end
        rx_valid     <= 1'b0;
        rx_byte.data <= ~q[n-1]; // released line shows no stale value
        repeat (2) @(posedge clk);
    endtask : send
endmodule : nhmp_peer

// ### nhmp_codec_tb.sv
module nhmp_codec_tb;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(nm, e, g) begin if ((g) !== (e)) begin $display("[FAIL] %s exp %0h got %0h", nm, e, g); n_errors++; end compares++; end
    logic clk, rst_n, rx_valid, rx_ready, rx_is_reply, fld_valid, fld_ready, rx_nak, rx_equiv_class;
    logic rx_mtu_default, rx_malformed, rx_done, ack_pulse, tx_new_req, tx_retry, tx_reply;
    logic enc_e164, enc_native, enc_has_sub, enc_is_atm, tx_nak, cache_load, cache_valid, cmp_in_class;
    logic [1:0]  ack_slot, tx_retry_slot, tx_slot;
    logic [3:0]  pending;
    logic [5:0]  enc_len;
    logic [7:0]  rx_prefix_eff, enc_type_len, enc_sub_type_len;
    logic [15:0] rx_pkt_size, rx_holding_time, enc_family, tx_hold_in, tx_holding_time;
    logic [31:0] rx_request_identifier, rx_src_key, tx_src_key, tx_request_identifier, cmp_addr_a, cmp_addr_b;
    nhmp_pkg::nhmp_byte_s rx_byte;
    nhmp_pkg::nhmp_out_s  fld;
    int n_errors = 0, compares = 0, nfld = 0;
    logic got_ack = 1'b0;
    nhmp_codec nhmp_codec_i (.*);
    nhmp_peer  nhmp_peer_i (.clk, .rx_ready, .rx_valid, .rx_byte, .rx_pkt_size);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // drained address octets must arrive in packet order
    always @(posedge clk) begin
        if (fld_valid === 1'b1 && fld_ready === 1'b1) begin
            `CHK("fld_data", 8'hA0 + nfld[7:0], fld.data)
            if (nfld == 0) `CHK("fld_head", {nhmp_pkg::F_SRC_NBMA, 1'b1, 8'h02}, {fld.field, fld.first, fld.len})
            if (nfld == 1) `CHK("fld_last", 1'b1, fld.last)
            nfld++;
        end
        if (ack_pulse === 1'b1) got_ack <= (ack_slot === 2'h0);
    end
    task automatic wrap_up;
        if (n_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up
    // one request pulse, then the identifier it produced
    task automatic issue(input logic nw, rt, input logic [1:0] sl, input logic [31:0] e);
        @(posedge clk);
        tx_new_req    <= nw;
        tx_retry      <= rt;
        tx_retry_slot <= sl;
        @(posedge clk);
        tx_new_req <= 1'b0;
        tx_retry   <= 1'b0;
        #1 `CHK("req_id", e, tx_request_identifier)
    endtask : issue
    // a hang is cut short well after the longest sequence
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        wrap_up();
    end
    initial begin
        {rst_n, rx_is_reply, fld_ready, tx_new_req, tx_retry, tx_reply, tx_nak, cache_load} = 8'h00;
        {enc_e164, enc_native, enc_has_sub, enc_is_atm, enc_len, tx_retry_slot} = 12'h000;
        {rx_src_key, tx_src_key, cmp_addr_a, cmp_addr_b, tx_hold_in} = '0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        // every format, subaddress and family combination
        for (int i = 0; i < 32; i++) begin
            @(posedge clk);
            {enc_e164, enc_native, enc_has_sub, enc_is_atm} <= i[4:1];
            enc_len <= i[0] ? 6'h05 : 6'h00;
            #1 `CHK("tl_top", 1'b0, enc_type_len[7])
            `CHK("tl_len", i[0] ? 6'h05 : 6'h00, enc_type_len[5:0])
            if (i[0]) `CHK("tl_fmt", i[4] && !i[3], enc_type_len[6])
            if (!i[2]) `CHK("sub_tl", 8'h00, enc_sub_type_len)
            if (i[1]) `CHK("family", i[2] ? 16'h000F : (i[4] ? 16'h0008 : 16'h0003), enc_family)
        end
        @(posedge clk);
        tx_hold_in <= 16'h1234;
        tx_nak     <= 1'b1;
        #1 `CHK("nak_hold", 16'h0000, tx_holding_time)
        @(posedge clk);
        tx_nak <= 1'b0;
        #1 `CHK("ack_hold", 16'h1234, tx_holding_time)
        tx_src_key <= 32'h0000CAFE;
        issue(1'b1, 1'b0, 2'h0, 32'h00000001);
        `CHK("pending", 1'b1, pending[0])
        issue(1'b1, 1'b0, 2'h0, 32'h00000002);
        issue(1'b0, 1'b1, 2'h0, 32'h00000001);
        `CHK("slot", 2'h2, tx_slot)
        // matching reply with a long address; the field buffer fills first
        rx_src_key  <= 32'h0000CAFE;
        rx_is_reply <= 1'b1;
        fork
            nhmp_peer_i.send(8'h14, 8'h02, 8'h00, 8'h00, 8'h00, 16'h0000, 16'h0003, 32'h1);
            begin
                for (int w = 0; w < 200 && rx_ready !== 1'b0; w++) @(posedge clk);
                `CHK("refused", 1'b0, rx_ready)
                fld_ready <= 1'b1;
            end
        join
        repeat (20) @(posedge clk);
        `CHK("octets", 24, nfld)
        `CHK("clean", 1'b0, rx_malformed)
        `CHK("ack", 1'b1, got_ack)
        `CHK("pend_clr", 1'b0, pending[0])
        `CHK("id", 32'h00000001, rx_request_identifier)
        `CHK("pos_ack", 1'b0, rx_nak)
        `CHK("prefix0", {8'hFF, 1'b0}, {rx_prefix_eff, rx_equiv_class})
        `CHK("mtu0", 1'b1, rx_mtu_default)
        `CHK("hold", 16'h0003, rx_holding_time)
        cache_load <= 1'b1;
        @(posedge clk);
        cache_load <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("cache", 1'b1, cache_valid)
        // negative reply with a real prefix and an unknown identifier
        nfld    = 0;
        got_ack = 1'b0;
        nhmp_peer_i.send(8'h01, 8'h02, 8'h00, 8'h05, 8'h18, 16'h05DC, 16'h0010, 32'h7);
        cmp_addr_a <= 32'h0A0B0C01;
        cmp_addr_b <= 32'h0A0B0CFF;
        repeat (4) @(posedge clk);
        `CHK("nak", {1'b1, 1'b1, 8'h18, 1'b0}, {rx_nak, rx_equiv_class, rx_prefix_eff, rx_mtu_default})
        `CHK("no_ack", 1'b0, got_ack)
        `CHK("in_class", 1'b1, cmp_in_class)
        cmp_addr_b <= 32'h0A0B0D01;
        #1 `CHK("out_class", 1'b0, cmp_in_class)
        // a reply carries the identifier of the packet just parsed
        @(posedge clk);
        tx_reply <= 1'b1;
        @(posedge clk);
        tx_reply <= 1'b0;
        #1 `CHK("reply_id", 32'h00000007, tx_request_identifier)
        // reserved bit set in the subaddress octet
        nfld = 0;
        nhmp_peer_i.send(8'h01, 8'h02, 8'h80, 8'h00, 8'h00, 16'h0000, 16'h0001, 32'h9);
        repeat (2) @(posedge clk);
        `CHK("malformed", 1'b1, rx_malformed)
        wrap_up();
    end
endmodule : nhmp_codec_tb
